// ---- tlc_top.sv ----
// Trip lockout latch, breaker wear trip counters, supervision warning routing
// and operation message priority, with an APB register slave.
// Assumes pins are asynchronous, stage and indication inputs are on pclk.
`timescale 1ns/100ps
`default_nettype none
module tlc_top (
   input  wire logic                                  pclk,
   input  wire logic                                  presetn,
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [tlc_pkg::ADDR_W-1:0]            paddr,
   input  wire logic [31:0]                           pwdata,
   output logic      [31:0]                           prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   input  wire logic                                  lockout_matrix_in,
   input  wire logic                                  so2_matrix_in,
   input  wire logic                                  ext_lockout_din,
   input  wire logic                                  lockout_reset_din,
   input  wire logic                                  panel_lockout_reset,
   input  wire logic                                  supervision_fault_in,
   input  wire logic                                  battery_ok,
   input  wire logic                                  nvm_lockout_in,
   input  wire logic [tlc_pkg::NUM_CNT*tlc_pkg::CNT_W-1:0] nvm_counts_in,
   input  wire logic [tlc_pkg::NUM_STG-1:0]           stage_trip,
   input  wire logic                                  breaker_failure_protection_ind,
   input  wire logic                                  trip_ind,
   input  wire logic                                  start_alarm_ind,
   input  wire logic                                  front_comm_active,
   output logic                                       lockout_power_output,
   output logic                                       second_signal_output,
   output logic                                       lockout_active,
   output logic [tlc_pkg::NUM_CNT*tlc_pkg::CNT_W-1:0] nvm_counts_out,
   output logic                                       nvm_store,
   output logic                                       nvm_lockout_out,
   output logic                                       sup_warning,
   output logic [7:0]                                 sup_fault_code,
   output logic [1:0]                                 display_msg,
   output logic                                       led_ready,
   output logic                                       led_start_alarm,
   output logic                                       led_trip,
   output logic [7:0]                                 led_prog,
   output logic                                       led_comm,
   output logic                                       irq
);
   import tlc_pkg::*;

   tlc_state_e               state_ff;
   logic [2:0]               init_cnt_ff;
   logic [2:0]               ctrl_ff;
   logic [7:0]               led_prog_ff;
   logic [NUM_EVT-1:0]       irq_st_ff;
   logic [NUM_EVT-1:0]       irq_en_ff;
   logic [NUM_SYNC-1:0]      sync_ff [3];
   logic [NUM_SYNC-1:0]      pin_ff;
   logic [NUM_SYNC-1:0]      pin_prev_ff;
   logic [CNT_W-1:0]         cnt_ff [NUM_CNT];
   logic                     seq_ff;
   logic                     lock_ff;
   logic                     lock_hold_ff;
   logic                     sup_warn_ff;
   logic                     so2_ff;
   logic                     po3_ff;
   logic                     store_ff;
   tlc_msg_e                 msg_ff;
   logic [31:0]              prdata_ff;
   logic                     wr_en;
   logic                     rd_en;
   logic                     run;
   logic                     lock_cause;
   logic                     lock_rst_req;
   logic                     cnt_clr;
   logic [NUM_CNT-1:0]       cnt_hit;
   logic [NUM_EVT-1:0]       evt;
   logic [NUM_EVT-1:0]       irq_clr;
   logic [31:0]              nxt_prdata;

   // Access completes in its first access cycle, so pready is tied high
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~penable & ~pwrite;
   assign run     = (state_ff == ST_RUN);

   // Power-up sequence: wait for pin synchronisers before restoring state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff    <= ST_INIT;
         init_cnt_ff <= 3'h0;
      end else begin
         case (state_ff)
            ST_INIT: begin
               init_cnt_ff <= init_cnt_ff + 3'h1;
               if (init_cnt_ff == 3'(INIT_CYC))
                  state_ff <= ST_RUN;
            end
            ST_RUN: state_ff <= ST_RUN;
            default: state_ff <= ST_INIT;
         endcase
      end
   end

   // Three-stage pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_ff[0]  <= '0;
         sync_ff[1]  <= '0;
         sync_ff[2]  <= '0;
         pin_ff      <= '0;
         pin_prev_ff <= '0;
      end else begin
         sync_ff[0] <= {battery_ok, supervision_fault_in, panel_lockout_reset,
                        lockout_reset_din, ext_lockout_din};
         sync_ff[1] <= sync_ff[0];
         sync_ff[2] <= sync_ff[1];
         for (int i = 0; i < NUM_SYNC; i++) begin
            if (sync_ff[1][i] == sync_ff[2][i])
               pin_ff[i] <= sync_ff[2][i];
         end
         pin_prev_ff <= pin_ff;
      end
   end

   // Control, LED and interrupt enable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff     <= CTRL_RESET;
         led_prog_ff <= 8'h00;
         irq_en_ff   <= '0;
      end else if (wr_en) begin
         if (paddr == REG_CTRL)
            ctrl_ff <= pwdata[2:0];
         else if (paddr == REG_LED)
            led_prog_ff <= pwdata[7:0];
         else if (paddr == REG_IRQ_EN)
            irq_en_ff <= pwdata[NUM_EVT-1:0];
      end
   end

   // Command strobes, one pulse per APB write or reset pin rising edge; lockout cause level
   assign cnt_clr = wr_en & (paddr == REG_CMD) & pwdata[CMD_CNT_CLR];
   assign irq_clr = (wr_en && paddr == REG_IRQ_CLR) ? pwdata[NUM_EVT-1:0] : '0;
   assign lock_cause = lockout_matrix_in | pin_ff[SY_EXT_LOCK];
   assign lock_rst_req = (wr_en & (paddr == REG_CMD) & pwdata[CMD_LOCK_RST])
                       | (pin_ff[SY_DIN_RST] & ~pin_prev_ff[SY_DIN_RST])
                       | (pin_ff[SY_PNL_RST] & ~pin_prev_ff[SY_PNL_RST]);

   // Lockout latch; a reset while the cause is present is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_ff <= 1'b1;
      end else if (!run) begin
         if (init_cnt_ff == 3'(INIT_CYC))
            lock_ff <= pin_ff[SY_BATT] ? nvm_lockout_in : 1'b1;
      end else if (ctrl_ff[CTRL_LOCK_EN] && lock_cause) begin
         lock_ff <= 1'b1;
      end else if (lock_rst_req && !lock_cause) begin
         lock_ff <= 1'b0;
      end
   end

   // Output three: closed while selected and no trip latched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         po3_ff <= 1'b0;
      else if (ctrl_ff[CTRL_LOCK_EN])
         po3_ff <= run & ~lock_ff;
      else
         po3_ff <= lockout_matrix_in;
   end

   // Group of each stage: three overcurrent stages, others share the last
   always_comb begin
      cnt_hit = '0;
      if (!seq_ff) begin
         for (int s = NUM_STG - 1; s >= 0; s--) begin
            if (stage_trip[s]) begin
               cnt_hit = '0;
               cnt_hit[(s < NUM_CNT - 1) ? s : NUM_CNT - 1] = 1'b1;
            end
         end
      end
   end

   // Fault sequence open from first trip until every trip has dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         seq_ff <= 1'b0;
      else
         seq_ff <= |stage_trip;
   end

   // Trip counters, loaded from storage then counting and wrapping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NUM_CNT; c++)
            cnt_ff[c] <= '0;
      end else if (!run) begin
         for (int c = 0; c < NUM_CNT; c++)
            cnt_ff[c] <= nvm_counts_in[c*CNT_W +: CNT_W];
      end else if (cnt_clr) begin
         for (int c = 0; c < NUM_CNT; c++)
            cnt_ff[c] <= '0;
      end else begin
         for (int c = 0; c < NUM_CNT; c++)
            if (cnt_hit[c])
               cnt_ff[c] <= cnt_ff[c] + CNT_W'(1);
      end
   end

   // Storage write strobe with each counter update, and one cycle after a lockout latch change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         store_ff <= 1'b0;
      else
         store_ff <= run & ((|cnt_hit) | cnt_clr | (lock_ff != lockout_active));
   end

   // Supervision warning and its optional routing to output two
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sup_warn_ff <= 1'b0;
         so2_ff      <= 1'b0;
      end else begin
         sup_warn_ff <= ctrl_ff[CTRL_SUP_EN] & pin_ff[SY_SUP_FLT];
         so2_ff      <= so2_matrix_in | (ctrl_ff[CTRL_ROUTE] & sup_warn_ff);
      end
   end

   // Only the highest ranked indication reaches the display
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         msg_ff <= MSG_NONE;
      else if (breaker_failure_protection_ind)
         msg_ff <= MSG_BREAKER_FAILURE_PROTECTION;
      else if (trip_ind)
         msg_ff <= MSG_TRIP;
      else if (start_alarm_ind)
         msg_ff <= MSG_START;
      else
         msg_ff <= MSG_NONE;
   end

   // Sticky events; a new event beats a clear in the same cycle
   assign evt[EV_LOCK] = run & ctrl_ff[CTRL_LOCK_EN] & lock_cause & ~lock_ff;
   assign evt[EV_TRIP] = run & (|cnt_hit); // Init loads storage, it does not count
   assign evt[EV_SUP]  = sup_warn_ff;
   assign evt[EV_WRAP] = run & (|(cnt_hit & {cnt_ff[3] == '1, cnt_ff[2] == '1,
                                             cnt_ff[1] == '1, cnt_ff[0] == '1}));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq_st_ff <= '0;
      else
         irq_st_ff <= (irq_st_ff & ~irq_clr) | evt;
   end

   // Read mux, captured in the setup phase
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      if (paddr == REG_CTRL)
         nxt_prdata[2:0] = ctrl_ff;
      else if (paddr == REG_STATUS)
         nxt_prdata[3:0] = {sup_warn_ff, so2_ff, po3_ff, lock_ff};
      else if (paddr == REG_LED)
         nxt_prdata[7:0] = led_prog_ff;
      else if (paddr == REG_CNT0)
         nxt_prdata[CNT_W-1:0] = cnt_ff[0];
      else if (paddr == REG_CNT1)
         nxt_prdata[CNT_W-1:0] = cnt_ff[1];
      else if (paddr == REG_CNT2)
         nxt_prdata[CNT_W-1:0] = cnt_ff[2];
      else if (paddr == REG_CNT3)
         nxt_prdata[CNT_W-1:0] = cnt_ff[3];
      else if (paddr == REG_IRQ_ST)
         nxt_prdata[NUM_EVT-1:0] = irq_st_ff;
      else if (paddr == REG_IRQ_EN)
         nxt_prdata[NUM_EVT-1:0] = irq_en_ff;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_ff <= 32'h0000_0000;
      else if (rd_en)
         prdata_ff <= nxt_prdata;
   end

   // Outputs
   assign prdata               = prdata_ff;
   assign lockout_power_output = po3_ff;
   assign second_signal_output = so2_ff;
   assign lockout_active       = lock_hold_ff;
   // Latch copy one cycle behind, so a change is seen before storage is written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         lock_hold_ff <= 1'b1;
      else
         lock_hold_ff <= lock_ff;
   end
   assign nvm_lockout_out = lock_hold_ff;
   for (genvar g = 0; g < NUM_CNT; g++) begin : g_nvm
      assign nvm_counts_out[g*CNT_W +: CNT_W] = cnt_ff[g];
   end
   assign nvm_store       = store_ff;
   assign sup_warning     = sup_warn_ff;
   assign sup_fault_code  = sup_warn_ff ? SUP_FAULT_CODE : 8'h00;
   assign display_msg     = msg_ff;
   assign led_ready       = run;
   assign led_start_alarm = start_alarm_ind;
   assign led_trip        = trip_ind;
   assign led_prog        = led_prog_ff;
   assign led_comm        = front_comm_active;
   assign irq             = |(irq_st_ff & irq_en_ff);
endmodule // tlc_top
`default_nettype wire

// ---- tlc_pkg.sv ----
// Constants, register map and types for the trip lockout and trip counter block.
// Assumes a 32-bit APB host and a single 20 MHz clock domain.
`default_nettype none
package tlc_pkg;
   localparam int CNT_W    = 16;
   localparam int NUM_CNT  = 4;
   localparam int NUM_STG  = 10;
   localparam int NUM_SYNC = 5;
   localparam int NUM_EVT  = 4;
   localparam int ADDR_W   = 8;
   localparam int INIT_CYC = 4; // Covers the three-flop pin path plus agreement
   // Register byte offsets
   localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CMD     = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h08;
   localparam logic [ADDR_W-1:0] REG_LED     = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_CNT0    = 8'h10;
   localparam logic [ADDR_W-1:0] REG_CNT1    = 8'h14;
   localparam logic [ADDR_W-1:0] REG_CNT2    = 8'h18;
   localparam logic [ADDR_W-1:0] REG_CNT3    = 8'h1C;
   localparam logic [ADDR_W-1:0] REG_IRQ_ST  = 8'h20;
   localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h24;
   localparam logic [ADDR_W-1:0] REG_IRQ_EN  = 8'h28;
   // Control and command bit positions
   localparam int CTRL_LOCK_EN = 0;
   localparam int CTRL_SUP_EN  = 1;
   localparam int CTRL_ROUTE   = 2;
   localparam int CMD_LOCK_RST = 0;
   localparam int CMD_CNT_CLR  = 1;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [7:0] SUP_FAULT_CODE = 8'h01; // arbitrary value
   // Sync channel indices
   localparam int SY_EXT_LOCK = 0;
   localparam int SY_DIN_RST  = 1;
   localparam int SY_PNL_RST  = 2;
   localparam int SY_SUP_FLT  = 3;
   localparam int SY_BATT     = 4;
   // Interrupt event bits
   localparam int EV_LOCK = 0;
   localparam int EV_TRIP = 1;
   localparam int EV_SUP  = 2;
   localparam int EV_WRAP = 3;
   // Display message codes, lowest priority first
   typedef enum logic [1:0] {
      MSG_NONE  = 2'h0,
      MSG_START = 2'h1,
      MSG_TRIP  = 2'h2,
      MSG_BREAKER_FAILURE_PROTECTION  = 2'h3
   } tlc_msg_e;
   typedef enum logic [1:0] {
      ST_INIT = 2'b01,
      ST_RUN  = 2'b10
   } tlc_state_e;
endpackage
`default_nettype wire

// ---- tlc_field_model.sv ----
// Far-side model: breaker trip circuit supervision and the digital input pins.
// Assumes the bench raises each request right after a rising pclk edge.
`timescale 1ns/100ps
`default_nettype none
module tlc_field_model (
   input  wire logic pclk,
   input  wire logic ext_req,
   input  wire logic din_req,
   input  wire logic pnl_req,
   input  wire logic flt_req,
   input  wire logic batt_req,
   output logic      ext_lockout_din = 1'b0,
   output logic      lockout_reset_din = 1'b0,
   output logic      panel_lockout_reset = 1'b0,
   output logic      supervision_fault_in = 1'b0,
   output logic      battery_ok = 1'b0
);
   // Pins settle one edge after a request, like a slow field contact
   always @(posedge pclk) begin
      ext_lockout_din      <= ext_req;
      lockout_reset_din    <= din_req;
      panel_lockout_reset  <= pnl_req;
      supervision_fault_in <= flt_req;
      battery_ok           <= batt_req;
   end
endmodule // tlc_field_model
`default_nettype wire

// ---- tlc_monitor.sv ----
// Port checker for the trip lockout and trip counter block.
// Assumes it sees top ports only; the control word is shadowed from APB writes.
`timescale 1ns/100ps
`default_nettype none
module tlc_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        lockout_matrix_in,
   input wire logic        so2_matrix_in,
   input wire logic [9:0]  stage_trip,
   input wire logic        breaker_failure_protection_ind,
   input wire logic        lockout_power_output,
   input wire logic        second_signal_output,
   input wire logic        lockout_active,
   input wire logic [63:0] nvm_counts_out,
   input wire logic        sup_warning,
   input wire logic [7:0]  sup_fault_code,
   input wire logic [1:0]  display_msg,
   input wire logic        led_ready
);
   import tlc_pkg::*;
   logic [2:0] ctrl_ff;
   logic       prev_any_ff;
   logic       wr_cyc;
   logic       clr_wr;
   logic [1:0] tgt;
   // Write strobes, and the counter a new sequence should hit (lowest index wins)
   assign wr_cyc = psel && penable && pwrite;
   assign clr_wr = wr_cyc && paddr == REG_CMD && pwdata[CMD_CNT_CLR];
   assign tgt = stage_trip[0] ? 2'h0 : stage_trip[1] ? 2'h1 : stage_trip[2] ? 2'h2 : 2'h3;
   // Shadow control word, taken at the same edge as the slave takes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CTRL_RESET;
      end else if (wr_cyc && paddr == REG_CTRL) begin
         ctrl_ff <= pwdata[2:0];
      end
   end
   // Trip level at the previous edge marks an ongoing sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_any_ff <= 1'b0;
      end else begin
         prev_any_ff <= |stage_trip;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_cause_held;
      led_ready && lockout_matrix_in ##1 lockout_active;
   endsequence
   sequence s_trip_seen;
      led_ready && ctrl_ff[CTRL_LOCK_EN] && lockout_matrix_in;
   endsequence
   AST_LOCK_HOLD: assert property (s_cause_held |=> lockout_active)
      else $error("lockout released while cause held");
   AST_LOCK_SET: assert property (s_trip_seen |-> ##2 lockout_active)
      else $error("lockout not set by matrix signal");
   AST_LOCK_OUT: assert property (led_ready && ctrl_ff[0] && $past(ctrl_ff[0])
      |-> lockout_power_output == !lockout_active) else $error("lockout output not inverse of latch");
   AST_CNT_INC: assert property (led_ready && (|stage_trip) && !prev_any_ff && !clr_wr
      |=> nvm_counts_out[$past(tgt)*16+:16] == 16'($past(nvm_counts_out[tgt*16+:16]) + 16'h0001))
      else $error("trip counter not advanced by one");
   AST_CNT_ONCE: assert property (led_ready && !((|stage_trip) && !prev_any_ff) && !clr_wr
      |=> $stable(nvm_counts_out)) else $error("counter moved outside a new sequence");
   AST_CNT_CLR: assert property (clr_wr |=> nvm_counts_out == '0)
      else $error("counters not cleared");
   AST_ROUTE: assert property (ctrl_ff[CTRL_ROUTE] && sup_warning |=> second_signal_output)
      else $error("warning not routed to second output");
   AST_SUP_CODE: assert property (sup_warning |-> sup_fault_code == SUP_FAULT_CODE)
      else $error("warning without fault code");
   AST_SUP_EN: assert property (!ctrl_ff[CTRL_SUP_EN] |=> !sup_warning)
      else $error("warning while supervision off");
   AST_MSG_TOP: assert property (breaker_failure_protection_ind |=> display_msg == MSG_BREAKER_FAILURE_PROTECTION)
      else $error("breaker failure message not on top");
endmodule // tlc_monitor
bind tlc_top tlc_monitor u_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .lockout_matrix_in, .so2_matrix_in, .stage_trip, .breaker_failure_protection_ind, .lockout_power_output, .second_signal_output,
   .lockout_active, .nvm_counts_out, .sup_warning, .sup_fault_code, .display_msg, .led_ready);
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench: APB master, trip stimulus and a counter model.
// Assumes tlc_pkg, tlc_top, the field model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import tlc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lockout_matrix_in, so2_matrix_in;
   logic        ext_lockout_din, lockout_reset_din, panel_lockout_reset, supervision_fault_in, battery_ok;
   logic        nvm_lockout_in, breaker_failure_protection_ind, trip_ind, start_alarm_ind, front_comm_active, lockout_power_output;
   logic        second_signal_output, lockout_active, nvm_store, nvm_lockout_out, sup_warning, led_ready;
   logic        led_start_alarm, led_trip, led_comm, irq, ext_req, din_req, pnl_req, flt_req, batt_req;
   logic [7:0]  paddr, sup_fault_code, led_prog;
   logic [31:0] pwdata, prdata, q, v;
   logic [63:0] nvm_counts_in, nvm_counts_out;
   logic [9:0]  stage_trip;
   logic [1:0]  display_msg;
   int          fails, comparisons, cnt[4];
   tlc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .lockout_matrix_in, .so2_matrix_in, .ext_lockout_din, .lockout_reset_din, .panel_lockout_reset,
      .supervision_fault_in, .battery_ok, .nvm_lockout_in, .nvm_counts_in, .stage_trip, .breaker_failure_protection_ind, .trip_ind,
      .start_alarm_ind, .front_comm_active, .lockout_power_output, .second_signal_output, .lockout_active,
      .nvm_counts_out, .nvm_store, .nvm_lockout_out, .sup_warning, .sup_fault_code, .display_msg, .led_ready,
      .led_start_alarm, .led_trip, .led_prog, .led_comm, .irq);
   tlc_field_model u_field (.pclk, .ext_req, .din_req, .pnl_req, .flt_req, .batt_req, .ext_lockout_din,
      .lockout_reset_din, .panel_lockout_reset, .supervision_fault_in, .battery_ok);
   // Compare, count and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // One APB transfer; waits on pready so no slave latency is assumed
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask
   task automatic rdcnt;
      for (int c = 0; c < 4; c++) rd(REG_CNT0 + 8'(4 * c), 32'(cnt[c]));
   endtask
   // Trip with a second pattern joining mid-sequence; only the first one counts
   task automatic trip(input logic [9:0] m1, input logic [9:0] m2);
      int f;
      f = 0;
      @(posedge pclk);
      stage_trip <= m1;
      @(posedge pclk);
      stage_trip <= m1 | m2;
      @(posedge pclk);
      stage_trip <= 10'h000;
      @(posedge pclk);
      while (!m1[f]) f++;
      f = (f < 3) ? f : 3;
      cnt[f] = (cnt[f] + 1) % 65536;
   endtask
   task automatic rst(input logic b, input logic n, input logic [63:0] cv);
      @(posedge pclk);
      presetn <= 1'b0;
      batt_req <= b;
      nvm_lockout_in <= n;
      nvm_counts_in <= cv;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      cyc(10);
      for (int c = 0; c < 4; c++) cnt[c] = cv[c*16+:16];
   endtask
   task automatic results;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Clock source
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Watchdog: the whole sequence needs a few thousand cycles at most
   initial begin
      #2_000_000;
      fails++;
      results();
   end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, lockout_matrix_in, so2_matrix_in, nvm_lockout_in} = '0;
      {breaker_failure_protection_ind, trip_ind, start_alarm_ind, front_comm_active, ext_req, din_req, pnl_req, flt_req} = '0;
      {batt_req, paddr, pwdata, nvm_counts_in, stage_trip} = '0;
      void'($urandom(93));
      rst(1'b0, 1'b1, 64'h0);
      chk(32'({led_ready, nvm_lockout_out, lockout_active}), 32'h0000_0007);
      rd(REG_CTRL, 32'h0000_0000);
      rd(8'h40, 32'h0000_0000);
      $display("test reset done");
      rst(1'b1, 1'b0, 64'hFFFF_0003_0002_0001);
      chk(32'({led_ready, nvm_lockout_out, lockout_active}), 32'h0000_0004);
      rdcnt();
      apb(1'b1, REG_IRQ_EN, 32'h0000_0002);
      trip(10'h200, 10'h001);
      for (int i = 0; i < 12; i++) trip(10'($urandom_range(1023, 1)), 10'($urandom()));
      cyc(1);
      chk(32'(irq), 32'h0000_0001);
      rdcnt();
      rd(REG_IRQ_ST, 32'h0000_000A);
      apb(1'b1, REG_IRQ_CLR, 32'h0000_000F);
      cyc(1);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, REG_IRQ_EN, 32'h0000_0000);
      trip(10'h001, 10'h000);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, REG_CMD, 32'h0000_0002);
      cyc(0);
      chk(32'(nvm_store), 32'h0000_0001);
      cnt = '{0, 0, 0, 0};
      rdcnt();
      $display("test counters done");
      apb(1'b1, REG_CTRL, 32'h0000_0001);
      cyc(2);
      chk(32'(lockout_power_output), 32'h0000_0001);
      for (int s = 0; s < 3; s++) begin
         @(posedge pclk);
         if (s == 1) ext_req <= 1'b1;
         else lockout_matrix_in <= 1'b1;
         cyc(12);
         chk(32'(lockout_power_output), 32'h0000_0000);
         apb(1'b1, REG_CMD, 32'h0000_0001);
         cyc(12);
         chk(32'(lockout_power_output), 32'h0000_0000);
         @(posedge pclk);
         ext_req <= 1'b0;
         lockout_matrix_in <= 1'b0;
         cyc(12);
         chk(32'(lockout_power_output), 32'h0000_0000);
         @(posedge pclk);
         if (s == 0) apb(1'b1, REG_CMD, 32'h0000_0001);
         else if (s == 1) din_req <= 1'b1;
         else pnl_req <= 1'b1;
         cyc(12);
         chk(32'(lockout_power_output), 32'h0000_0001);
         @(posedge pclk);
         din_req <= 1'b0;
         pnl_req <= 1'b0;
      end
      $display("test lockout done");
      apb(1'b1, REG_CTRL, 32'h0000_0006);
      flt_req <= 1'b1;
      cyc(10);
      chk({24'h0, sup_fault_code}, 32'(SUP_FAULT_CODE));
      chk(32'(second_signal_output), 32'h0000_0001);
      apb(1'b1, REG_CTRL, 32'h0000_0004);
      cyc(3);
      chk(32'({sup_warning, second_signal_output}), 32'h0000_0000);
      @(posedge pclk);
      so2_matrix_in <= 1'b1;
      cyc(3);
      chk(32'(second_signal_output), 32'h0000_0001);
      rd(REG_STATUS, 32'h0000_0004);
      // Lockout, trip and warning events all stayed sticky since the last clear
      rd(REG_IRQ_ST, 32'h0000_0007);
      $display("test supervision done");
      for (int i = 0; i < 8; i++) begin
         @(posedge pclk);
         {front_comm_active, breaker_failure_protection_ind, trip_ind, start_alarm_ind} <= 4'(i + (i << 1) * 4);
         cyc(2);
         chk(32'(display_msg), (i[2]) ? 32'h3 : (i[1]) ? 32'h2 : 32'(i[0]));
         // The comm input rides on bit zero of the drive pattern
         chk(32'({led_comm, led_trip, led_start_alarm}), 32'({i[0], i[1], i[0]}));
      end
      v = $urandom();
      apb(1'b1, REG_LED, v);
      rd(REG_LED, {24'h0, v[7:0]});
      chk({24'h0, led_prog}, {24'h0, v[7:0]});
      $display("test indication done");
      results();
   end
endmodule // tb_top
`default_nettype wire
